// [t3e3_overhead_port_control.sv]
// per-port overhead access control: AHB-Lite registers, receive marking and gapping, transmit insert
`timescale 1ns/1ps
module t3e3_overhead_port_control
  import ovh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // framer context, same clock
  input wire logic [1:0] frame_mode,
  input wire logic rx_los,
  input wire logic rx_oof,
  input wire logic [3:0] rx_field_in,
  input wire logic [3:0] tx_field_in,
  input wire logic tx_internal_bit,
  input wire logic tx_stream_bit,
  input wire logic tx_msg_done,
  input wire logic tx_underrun,
  input wire logic tx_near_empty,
  input wire logic rx_dl_irq,
  // line pins
  input wire logic rx_line_clk_in,
  input wire logic rx_line_data_in,
  input wire logic tx_line_clk_in,
  input wire logic tx_overhead_insert_in,
  output logic rx_serial_data_out,
  output logic rx_gapped_clk_out,
  output logic rx_field_marker_clk_out,
  output logic tx_line_data_out,
  output logic tx_bit_strobe,
  // controls to the data-link engines, and the host interrupt
  output logic tx_crc_append_en,
  output logic rx_link_channel_en,
  output logic host_irq_n
);

  typedef struct packed {
    logic [7:0] insert_ctrl;
    logic [7:0] marker_ctrl;
    logic [7:0] gap_ctrl;
    logic [7:0] dl_ctrl;
    logic [7:0] aux_ctrl;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [2:0] rx_clk_sync;
    logic [2:0] tx_clk_sync;
    logic [1:0] rx_data_sync;
    logic [1:0] pin_sync;
    logic rx_tick;
    logic rx_mark;
    logic rx_data;
    logic gclk;
    logic mclk;
    logic tx_data;
    logic tx_strobe;
    logic crc_en;
    logic dl_en;
    logic irq_n;
  } state_t;

  state_t q;
  state_t d;
  logic rx_rise;
  logic tx_rise;
  logic irq_any;
  logic [7:0] rd_val;

  ovh_sel_if sel ();

  rx_field_select u_rx (
    .sel(sel.rx)
  );

  tx_insert_select u_tx (
    .sel(sel.tx)
  );

  // register read view; status bits show live block state
  function automatic logic [7:0] reg_read(input logic [7:0] idx, input state_t s,
                                          input logic [3:0] st);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      IDX_INSERT_CTRL: v = s.insert_ctrl;
      IDX_MARKER_CTRL: v = s.marker_ctrl;
      IDX_GAP_CTRL: v = s.gap_ctrl;
      IDX_DL_CTRL: v = s.dl_ctrl;
      IDX_AUX_CTRL: v = s.aux_ctrl | {st, 4'h0};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign sel.mode = frame_mode_t'(frame_mode);
  assign sel.rx_cls = field_class_t'(rx_field_in);
  assign sel.tx_cls = field_class_t'(tx_field_in);
  assign sel.marker_ctrl = q.marker_ctrl;
  assign sel.gap_ctrl = q.gap_ctrl;
  assign sel.insert_ctrl = q.insert_ctrl;
  assign sel.auto_alarm_en = q.aux_ctrl[B_AUTO_REMOTE_ALARM_EN];
  assign sel.override = q.aux_ctrl[B_STREAM_OVERHEAD_OVERRIDE];
  assign sel.los = rx_los;
  assign sel.oof = rx_oof;
  assign sel.pin_bit = q.pin_sync[1];
  assign sel.int_bit = tx_internal_bit;
  assign sel.stream_bit = tx_stream_bit;

  always_comb begin
    d = q;
    // synchronisers: the first stage feeds only the second
    d.rx_clk_sync = {q.rx_clk_sync[1:0], rx_line_clk_in};
    d.tx_clk_sync = {q.tx_clk_sync[1:0], tx_line_clk_in};
    d.rx_data_sync = {q.rx_data_sync[0], rx_line_data_in};
    d.pin_sync = {q.pin_sync[0], tx_overhead_insert_in};
    rx_rise = q.rx_clk_sync[1] && !q.rx_clk_sync[2];
    tx_rise = q.tx_clk_sync[1] && !q.tx_clk_sync[2];

    // bus write lands in the data phase; reserved bits are never stored
    if (q.wr_pend) begin
      unique case (q.wr_idx)
        IDX_INSERT_CTRL: d.insert_ctrl = hwdata[7:0] & MASK_INSERT_CTRL;
        IDX_MARKER_CTRL: d.marker_ctrl = hwdata[7:0] & MASK_MARKER_CTRL;
        IDX_GAP_CTRL: d.gap_ctrl = hwdata[7:0] & MASK_GAP_CTRL;
        IDX_DL_CTRL: d.dl_ctrl = hwdata[7:0] & MASK_DL_CTRL; // RULE25
        IDX_AUX_CTRL: d.aux_ctrl = hwdata[7:0] & MASK_AUX_CTRL;
        default: d.wr_pend = 1'b0;
      endcase
    end
    d.wr_pend = 1'b0;
    d.hreadyout = 1'b1;

    irq_any = (q.dl_ctrl[B_TX_MSG_DONE_IRQ_EN] && tx_msg_done) || // RULE21
              (q.dl_ctrl[B_TX_UNDERRUN_IRQ_EN] && tx_underrun) || // RULE22
              (q.dl_ctrl[B_TX_NEAR_EMPTY_IRQ_EN] && tx_near_empty) || // RULE23
              (q.aux_ctrl[B_RX_LINK_CHANNEL_EN] && rx_dl_irq); // RULE20
    d.irq_n = !irq_any;

    // read data reflects a write still in its data phase
    rd_val = reg_read(haddr[9:2], d, {!q.irq_n, sel.auto_alarm, rx_oof, rx_los});
    if (hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)) begin
      d.wr_pend = hwrite;
      d.wr_idx = haddr[9:2];
      d.hrdata = hwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
    end

    d.crc_en = q.dl_ctrl[B_TX_CRC_APPEND_EN]; // RULE24
    d.dl_en = q.aux_ctrl[B_RX_LINK_CHANNEL_EN]; // RULE20

    // receive: decide tick and mark on the line clock rising edge
    if (rx_rise) begin
      d.rx_tick = sel.rx_tick;
      d.rx_mark = sel.rx_mark; // RULE7
      d.rx_data = q.rx_data_sync[1];
    end
    d.gclk = q.rx_clk_sync[1] && (rx_rise ? sel.rx_tick : q.rx_tick); // RULE19
    d.mclk = q.rx_clk_sync[1] && (rx_rise ? sel.rx_mark : q.rx_mark);

    // transmit: one bit per line clock rising edge
    d.tx_strobe = tx_rise;
    if (tx_rise) begin
      d.tx_data = sel.tx_bit;
    end

    if (!rst_n) begin
      d = '0;
      d.insert_ctrl = RST_INSERT_CTRL;
      d.marker_ctrl = RST_MARKER_CTRL;
      d.gap_ctrl = RST_GAP_CTRL;
      d.dl_ctrl = RST_DL_CTRL;
      d.aux_ctrl = RST_AUX_CTRL;
      d.hreadyout = 1'b1;
      d.irq_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign rx_serial_data_out = q.rx_data;
  assign rx_gapped_clk_out = q.gclk;
  assign rx_field_marker_clk_out = q.mclk;
  assign tx_line_data_out = q.tx_data;
  assign tx_bit_strobe = q.tx_strobe;
  assign tx_crc_append_en = q.crc_en;
  assign rx_link_channel_en = q.dl_en;
  assign host_irq_n = q.irq_n;

endmodule // t3e3_overhead_port_control

// [ovh_pkg.sv]
// constants, types and the register map of the overhead port control block
// Summary of operation
// RULE1: external stuff bits from insert pin, M13/G.751
// RULE2: alignment bits from insert pin when selected
// RULE3: DS3 P-bits from insert pin when selected
// RULE4: X/A/RDI from pin, E3 only without auto
// RULE5: auto RAI/RDI while LOS or OOF
// RULE6: override takes stream bits except alarm bits
// RULE7: marker selection independent of gapping and host
// RULE8: mark reserved C-bits or GC byte
// RULE9: mark raw data-link bits, bypassing HDLC
// RULE10: mark FEBE, REI or A-bit
// RULE11: mark CP field or timing marker
// RULE12: mark FEAC, PD/MI or stuff bits
// RULE13: mark AIC, justification or trail trace
// RULE14: mark framing fields per mode
// RULE15: full-frame marking overrides all other marks
// RULE16: gapped clock ticks on stuff bits if selected
// RULE17: gapped clock ticks on justification bits if selected
// RULE18: all-overhead makes gapped clock nominal
// RULE19: other opportunity bits withheld when gapping
// RULE20: data-link disabled: no receive data-link interrupts
// RULE21: message-done enable drives host interrupt
// RULE22: underrun enable drives host interrupt
// RULE23: near-empty enable drives host interrupt
// RULE24: frame check append enable to HDLC engine
// RULE25: software writes zero to reserved bits
package ovh_pkg;

  typedef enum logic [1:0] {
    MODE_M13 = 2'h0,
    MODE_CBIT = 2'h1,
    MODE_G751 = 2'h2,
    MODE_G832 = 2'h3
  } frame_mode_t;

  typedef enum logic [3:0] {
    FLD_PAYLOAD = 4'h0,
    FLD_STUFF = 4'h1,
    FLD_JUST = 4'h2,
    FLD_ALIGN = 4'h3,
    FLD_PARITY = 4'h4,
    FLD_ALARM = 4'h5,
    FLD_FRAMING = 4'h6,
    FLD_RESERVED_GC = 4'h7,
    FLD_DATALINK = 4'h8,
    FLD_FEBE_REI = 4'h9,
    FLD_CP_TM = 4'hA,
    FLD_FEAC_PD = 4'hB,
    FLD_AIC_TRAIL = 4'hC
  } field_class_t;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_INSERT_CTRL = 8'h2A;
  localparam logic [7:0] IDX_MARKER_CTRL = 8'h2B;
  localparam logic [7:0] IDX_GAP_CTRL = 8'h2C;
  localparam logic [7:0] IDX_DL_CTRL = 8'h2D;
  localparam logic [7:0] IDX_AUX_CTRL = 8'h3C;

  localparam logic [7:0] RST_INSERT_CTRL = 8'h00;
  localparam logic [7:0] RST_MARKER_CTRL = 8'h00;
  localparam logic [7:0] RST_GAP_CTRL = 8'h00;
  localparam logic [7:0] RST_DL_CTRL = 8'h00;
  localparam logic [7:0] RST_AUX_CTRL = 8'h00;

  // writable bits of each register
  localparam logic [7:0] MASK_INSERT_CTRL = 8'h0F;
  localparam logic [7:0] MASK_MARKER_CTRL = 8'hFF;
  localparam logic [7:0] MASK_GAP_CTRL = 8'h07;
  localparam logic [7:0] MASK_DL_CTRL = 8'h0F;
  localparam logic [7:0] MASK_AUX_CTRL = 8'h07;

  // insert control bits
  localparam int B_EXT_ALARM_BIT_INSERT = 0;
  localparam int B_EXT_PARITY_INSERT = 1;
  localparam int B_EXT_ALIGN_INSERT = 2;
  localparam int B_EXT_STUFF_INSERT = 3;
  // marker control bits
  localparam int B_MARK_FULL_FRAME = 0;
  localparam int B_MARK_FRAMING_FIELDS = 1;
  localparam int B_MARK_AIC_JUST_TRAIL = 2;
  localparam int B_MARK_FEAC_PD_STUFF = 3;
  localparam int B_MARK_PATH_PARITY_TIMING = 4;
  localparam int B_MARK_FEBE_REI_ABIT = 5;
  localparam int B_MARK_DATALINK_RAW = 6;
  localparam int B_MARK_RESERVED_OR_GC = 7;
  // gap control bits
  localparam int B_RX_ALL_OVERHEAD_IN_STREAM = 0;
  localparam int B_RX_JUST_IN_STREAM = 1;
  localparam int B_RX_STUFF_IN_STREAM = 2;
  // data-link control bits
  localparam int B_TX_CRC_APPEND_EN = 0;
  localparam int B_TX_NEAR_EMPTY_IRQ_EN = 1;
  localparam int B_TX_UNDERRUN_IRQ_EN = 2;
  localparam int B_TX_MSG_DONE_IRQ_EN = 3;
  // auxiliary control and status bits
  localparam int B_AUTO_REMOTE_ALARM_EN = 0;
  localparam int B_STREAM_OVERHEAD_OVERRIDE = 1;
  localparam int B_RX_LINK_CHANNEL_EN = 2;
  localparam int B_ST_RX_LOS = 4;
  localparam int B_ST_RX_OOF = 5;
  localparam int B_ST_AUTO_ALARM = 6;
  localparam int B_ST_IRQ = 7;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

endpackage

// [ovh_sel_if.sv]
// carrier between the control top and its receive and transmit selectors
`timescale 1ns/1ps
interface ovh_sel_if;
  import ovh_pkg::*;
  frame_mode_t mode;
  field_class_t rx_cls;
  field_class_t tx_cls;
  logic [7:0] marker_ctrl;
  logic [7:0] gap_ctrl;
  logic [7:0] insert_ctrl;
  logic auto_alarm_en;
  logic override;
  logic los;
  logic oof;
  logic pin_bit;
  logic int_bit;
  logic stream_bit;
  logic rx_mark;
  logic rx_tick;
  logic tx_bit;
  logic auto_alarm;

  modport ctl (
    output mode, rx_cls, tx_cls, marker_ctrl, gap_ctrl, insert_ctrl, auto_alarm_en,
    output override, los, oof, pin_bit, int_bit, stream_bit,
    input rx_mark, rx_tick, tx_bit, auto_alarm
  );
  modport rx (
    input mode, rx_cls, marker_ctrl, gap_ctrl,
    output rx_mark, rx_tick
  );
  modport tx (
    input mode, tx_cls, insert_ctrl, auto_alarm_en, override, los, oof,
    input pin_bit, int_bit, stream_bit,
    output tx_bit, auto_alarm
  );
endinterface

// [rx_field_select.sv]
// receive field marking and gapped-clock tick decision for one bit
`timescale 1ns/1ps
module rx_field_select
  import ovh_pkg::*;
(
  ovh_sel_if.rx sel
);

  function automatic logic is_ds3(input frame_mode_t m);
    return (m == MODE_M13) || (m == MODE_CBIT);
  endfunction

  function automatic logic has_opp(input frame_mode_t m);
    return (m == MODE_M13) || (m == MODE_G751);
  endfunction

  logic [7:0] hit;
  frame_mode_t m;
  field_class_t c;

  always_comb begin
    m = sel.mode;
    c = sel.rx_cls;
    hit = 8'h00;
    hit[B_MARK_FULL_FRAME] = 1'b1; // RULE15
    hit[B_MARK_FRAMING_FIELDS] = (c == FLD_ALIGN) ||
      ((is_ds3(m) || m == MODE_G832) && (c == FLD_ALARM || c == FLD_FRAMING)) ||
      (is_ds3(m) && c == FLD_PARITY); // RULE14
    hit[B_MARK_AIC_JUST_TRAIL] = has_opp(m) ? (c == FLD_JUST) : (c == FLD_AIC_TRAIL); // RULE13
    hit[B_MARK_FEAC_PD_STUFF] = has_opp(m) ? (c == FLD_STUFF) : (c == FLD_FEAC_PD); // RULE12
    hit[B_MARK_PATH_PARITY_TIMING] = !has_opp(m) && (c == FLD_CP_TM); // RULE11
    hit[B_MARK_FEBE_REI_ABIT] = (m == MODE_G751) ? (c == FLD_ALARM) :
      ((m != MODE_M13) && (c == FLD_FEBE_REI)); // RULE10
    hit[B_MARK_DATALINK_RAW] = (m != MODE_M13) && (c == FLD_DATALINK); // RULE9
    hit[B_MARK_RESERVED_OR_GC] = !has_opp(m) && (c == FLD_RESERVED_GC); // RULE8
    // full-frame selection alone marks every bit
    sel.rx_mark = sel.marker_ctrl[B_MARK_FULL_FRAME] || |(sel.marker_ctrl & hit); // RULE15
    // tick decision reads only the gap register, never the marker one
    if (sel.gap_ctrl[B_RX_ALL_OVERHEAD_IN_STREAM]) begin // RULE7
      sel.rx_tick = 1'b1; // RULE18
    end else if (c == FLD_PAYLOAD) begin
      sel.rx_tick = 1'b1;
    end else if (has_opp(m) && c == FLD_STUFF) begin
      sel.rx_tick = sel.gap_ctrl[B_RX_STUFF_IN_STREAM]; // RULE16
    end else if (has_opp(m) && c == FLD_JUST) begin
      sel.rx_tick = sel.gap_ctrl[B_RX_JUST_IN_STREAM]; // RULE17
    end else begin
      sel.rx_tick = 1'b0; // RULE19
    end
  end

endmodule // rx_field_select

// [tx_insert_select.sv]
// transmit opportunity bit source selection for one bit
`timescale 1ns/1ps
module tx_insert_select
  import ovh_pkg::*;
(
  ovh_sel_if.tx sel
);

  logic e3;
  logic ds3_opp;
  logic ext_alarm_ok;

  always_comb begin
    e3 = (sel.mode == MODE_G751) || (sel.mode == MODE_G832);
    ds3_opp = (sel.mode == MODE_M13) || (sel.mode == MODE_G751);
    sel.auto_alarm = e3 && sel.auto_alarm_en && (sel.los || sel.oof); // RULE5
    ext_alarm_ok = sel.insert_ctrl[B_EXT_ALARM_BIT_INSERT] && !(e3 && sel.auto_alarm_en); // RULE4
    sel.tx_bit = sel.int_bit;
    unique case (sel.tx_cls)
      FLD_PAYLOAD: begin
        sel.tx_bit = sel.stream_bit;
      end
      FLD_ALARM: begin
        // alarm bits keep their own sources even under the override
        if (sel.auto_alarm) begin
          sel.tx_bit = 1'b1; // RULE5
        end else if (ext_alarm_ok) begin
          sel.tx_bit = sel.pin_bit; // RULE4
        end
      end
      FLD_STUFF: begin
        if (!sel.override && ds3_opp && sel.insert_ctrl[B_EXT_STUFF_INSERT]) begin
          sel.tx_bit = sel.pin_bit; // RULE1
        end else begin
          sel.tx_bit = sel.stream_bit; // RULE1
        end
      end
      FLD_ALIGN: begin
        if (sel.override) begin
          sel.tx_bit = sel.stream_bit; // RULE6
        end else if (sel.insert_ctrl[B_EXT_ALIGN_INSERT]) begin
          sel.tx_bit = sel.pin_bit; // RULE2
        end
      end
      FLD_PARITY: begin
        if (sel.override) begin
          sel.tx_bit = sel.stream_bit; // RULE6
        end else if (!e3 && sel.insert_ctrl[B_EXT_PARITY_INSERT]) begin
          sel.tx_bit = sel.pin_bit; // RULE3
        end
      end
      default: begin
        if (sel.override) begin
          sel.tx_bit = sel.stream_bit; // RULE6
        end
      end
    endcase
  end

endmodule // tx_insert_select

// [t3e3_overhead_port_control_assertions.sv]
// concurrent checks on the overhead port control top-level ports
`timescale 1ns/1ps
module t3e3_overhead_port_control_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic tx_msg_done,
  input wire logic tx_underrun,
  input wire logic tx_near_empty,
  input wire logic rx_dl_irq,
  input wire logic host_irq_n,
  input wire logic rx_line_clk_in,
  input wire logic tx_line_clk_in,
  input wire logic tx_line_data_out,
  input wire logic tx_bit_strobe,
  input wire logic rx_gapped_clk_out,
  input wire logic rx_field_marker_clk_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic any_event;
  assign any_event = tx_msg_done | tx_underrun | tx_near_empty | rx_dl_irq;
  sequence tx_edge_seen;
    $rose(tx_line_clk_in);
  endsequence
  sequence strobe_then_quiet;
    tx_bit_strobe ##1 !tx_bit_strobe [*8];
  endsequence
  // gated clocks may only be high a few cycles after the line clock pin was high
  property follows_rx_clock(logic g);
    g |-> ($past(rx_line_clk_in, 2) || $past(rx_line_clk_in, 3) ||
      $past(rx_line_clk_in, 4) || $past(rx_line_clk_in, 5));
  endproperty
  a_ready_always: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("hrdata upper bits set");
  a_irq_has_cause: assert property (!host_irq_n |-> $past(any_event))
    else $error("interrupt without event");
  a_irq_quiet: assert property (!any_event |=> host_irq_n)
    else $error("interrupt held with no event");
  a_strobe_after_edge: assert property (tx_edge_seen |-> ##[1:6] strobe_then_quiet)
    else $error("no single strobe after transmit clock rise");
  a_data_with_strobe: assert property ($changed(tx_line_data_out) |-> tx_bit_strobe)
    else $error("transmit data changed without strobe");
  a_gclk_follows_clock: assert property (follows_rx_clock(rx_gapped_clk_out))
    else $error("gapped clock high outside line clock");
  a_mark_follows_clock: assert property (follows_rx_clock(rx_field_marker_clk_out))
    else $error("marker clock high outside line clock");
endmodule // t3e3_overhead_port_control_assertions

// [ovh_far_end.sv]
// far-side overhead logic: line clock within frames, receive data and insert pin
`timescale 1ns/1ps
module ovh_far_end (
  input wire logic run,
  input wire logic ins_val,
  output logic line_clk,
  output logic rx_data,
  output logic ins_pin
);
  initial begin
    line_clk = 1'b0;
    rx_data = 1'b0;
    ins_pin = 1'b0;
    #1.3;
    forever begin
      if (run) begin
        rx_data = ~rx_data;
        ins_pin = ins_val;
        #80 line_clk = 1'b1;
        #80 line_clk = 1'b0;
      end else begin
        // insert pin not driven outside frames: no stable level
        ins_pin = ~ins_pin;
        #12;
      end
    end
  end
endmodule // ovh_far_end

// [tb_t3e3_overhead_port_control.sv]
// self-checking bench for the overhead port control block
`timescale 1ns/1ps
module tb_t3e3_overhead_port_control
  import ovh_pkg::*;
;
  typedef struct packed {
    logic [1:0] m;
    logic [3:0] f;
    logic [7:0] ins;
    logic [7:0] mrk;
    logic [7:0] gap;
    logic [7:0] aux;
    logic [4:0] fl;
  } row_t;
  // fl: los, insert pin, expected tick, expected mark, expected tx bit
  row_t rows [16] = '{
    '{MODE_M13,4'h1,8'h08,8'h08,8'h04,8'h00,5'b00110},
    '{MODE_M13,4'h1,8'h00,8'h00,8'h00,8'h00,5'b00001},
    '{MODE_G751,4'h2,8'h00,8'h04,8'h02,8'h00,5'b0011x},
    '{MODE_M13,4'h2,8'h00,8'h00,8'h04,8'h00,5'b0000x},
    '{MODE_CBIT,4'h1,8'h08,8'h01,8'h01,8'h00,5'b00111},
    '{MODE_M13,4'h4,8'h02,8'h02,8'h00,8'h00,5'b01011},
    '{MODE_G751,4'h4,8'h02,8'h00,8'h00,8'h00,5'b01000},
    '{MODE_G832,4'h3,8'h04,8'h02,8'h00,8'h00,5'b01011},
    '{MODE_G832,4'h5,8'h01,8'h00,8'h00,8'h00,5'b01001},
    '{MODE_G832,4'h5,8'h01,8'h00,8'h00,8'h01,5'b01000},
    '{MODE_G751,4'h5,8'h00,8'h20,8'h00,8'h01,5'b10011},
    '{MODE_CBIT,4'h4,8'h00,8'h00,8'h00,8'h02,5'b00001},
    '{MODE_CBIT,4'h7,8'h00,8'h80,8'h00,8'h00,5'b0001x},
    '{MODE_M13,4'h7,8'h00,8'h80,8'h00,8'h00,5'b0000x},
    '{MODE_G751,4'h8,8'h00,8'h40,8'h00,8'h00,5'b0001x},
    '{MODE_G832,4'hA,8'h00,8'h10,8'h00,8'h00,5'b0001x}
  };
  logic [7:0] ri [5] = '{IDX_INSERT_CTRL, IDX_MARKER_CTRL, IDX_GAP_CTRL, IDX_DL_CTRL, IDX_AUX_CTRL};
  logic [7:0] rv [5] = '{RST_INSERT_CTRL, RST_MARKER_CTRL, RST_GAP_CTRL, RST_DL_CTRL, RST_AUX_CTRL};
  logic [7:0] rm [5] = '{MASK_INSERT_CTRL, MASK_MARKER_CTRL, MASK_GAP_CTRL, MASK_DL_CTRL, MASK_AUX_CTRL};
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, run, ins_val, clr, rx_los, rx_dl_irq;
  logic line_clk, rx_data, ins_pin, rx_serial_data_out, rx_gapped_clk_out, rx_field_marker_clk_out;
  logic tx_line_data_out, tx_bit_strobe, tx_crc_append_en, rx_link_channel_en, host_irq_n;
  logic tk, mk, st, txv, dv, rx_oof;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, frame_mode;
  logic [2:0] ev;
  logic [3:0] fld;
  int bad_count, samples_checked;
  row_t r;

  t3e3_overhead_port_control uut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .frame_mode(frame_mode), .rx_los(rx_los), .rx_oof(rx_oof),
    .rx_field_in(fld), .tx_field_in(fld), .tx_internal_bit(1'b0), .tx_stream_bit(1'b1),
    .tx_msg_done(ev[2]), .tx_underrun(ev[1]), .tx_near_empty(ev[0]), .rx_dl_irq(rx_dl_irq),
    .rx_line_clk_in(line_clk), .rx_line_data_in(rx_data), .tx_line_clk_in(line_clk),
    .tx_overhead_insert_in(ins_pin), .rx_serial_data_out(rx_serial_data_out),
    .rx_gapped_clk_out(rx_gapped_clk_out), .rx_field_marker_clk_out(rx_field_marker_clk_out),
    .tx_line_data_out(tx_line_data_out), .tx_bit_strobe(tx_bit_strobe),
    .tx_crc_append_en(tx_crc_append_en), .rx_link_channel_en(rx_link_channel_en),
    .host_irq_n(host_irq_n));

  ovh_far_end far (.run(run), .ins_val(ins_val), .line_clk(line_clk), .rx_data(rx_data),
    .ins_pin(ins_pin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // collects what the line outputs did during one frame
  always @(posedge clk) begin
    tk <= !clr && (tk || rx_gapped_clk_out === 1'b1);
    mk <= !clr && (mk || rx_field_marker_clk_out === 1'b1);
    st <= !clr && (st || tx_bit_strobe === 1'b1);
    dv <= !clr && (dv || rx_serial_data_out === 1'b1);
    if (tx_bit_strobe === 1'b1) txv <= tx_line_data_out;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      check("hready", 32'h1, 32'(hreadyout));
      finish_test();
    end
  endtask

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata;
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    frame_mode = 2'h0;
    fld = 4'h0;
    rx_los = 1'b0;
    rx_oof = 1'b0;
    rx_dl_irq = 1'b0;
    ev = 3'h0;
    run = 1'b0;
    ins_val = 1'b0;
    clr = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("irq_n reset", 32'h1, 32'(host_irq_n));
    check("tx data reset", 32'h0, 32'(tx_line_data_out));
    for (int i = 0; i < 5; i++) begin
      bus(ri[i], 1'b0, 8'h00);
      check("reset value", 32'(rv[i]), rd);
      bus(ri[i], 1'b1, (ri[i] == IDX_DL_CTRL) ? MASK_DL_CTRL : 8'hFF);
      bus(ri[i], 1'b0, 8'h00);
      check("write read", 32'(rm[i]), rd);
    end
    bus(8'h10, 1'b1, 8'hFF);
    bus(8'h10, 1'b0, 8'h00);
    check("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      r = rows[i];
      bus(IDX_INSERT_CTRL, 1'b1, r.ins);
      bus(IDX_MARKER_CTRL, 1'b1, r.mrk);
      bus(IDX_GAP_CTRL, 1'b1, r.gap);
      bus(IDX_AUX_CTRL, 1'b1, r.aux);
      frame_mode <= r.m;
      fld <= r.f;
      rx_los <= r.fl[4];
      ins_val <= r.fl[3];
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      run <= 1'b1;
      repeat (60) @(posedge clk);
      run <= 1'b0;
      repeat (50) @(posedge clk);
      check("gapped clock", 32'(r.fl[2]), 32'(tk));
      check("marker clock", 32'(r.fl[1]), 32'(mk));
      check("tx strobe", 32'h1, 32'(st));
      if (r.fl[0] !== 1'bx) check("tx data", 32'(r.fl[0]), 32'(txv));
      // far end sends 1 then 0 in every frame
      check("rx data seen", 32'h1, 32'(dv));
      check("rx data last", 32'h0, 32'(rx_serial_data_out));
    end
    // out-of-frame alone raises the automatic alarm in an E3 mode
    frame_mode <= MODE_G832;
    rx_los <= 1'b0;
    rx_oof <= 1'b1;
    bus(IDX_AUX_CTRL, 1'b1, 8'h01);
    bus(IDX_AUX_CTRL, 1'b0, 8'h00);
    check("auto alarm oof", 32'h61, rd);
    rx_oof <= 1'b0;
    bus(IDX_AUX_CTRL, 1'b1, 8'h00);
    for (int b = 0; b < 3; b++) begin
      bus(IDX_DL_CTRL, 1'b1, 8'h02 << b);
      ev <= 3'h7 ^ (3'h1 << b);
      rx_dl_irq <= 1'b1;
      repeat (3) @(posedge clk);
      check("irq masked", 32'h1, 32'(host_irq_n));
      ev <= 3'h1 << b;
      rx_dl_irq <= 1'b0;
      repeat (3) @(posedge clk);
      check("irq raised", 32'h0, 32'(host_irq_n));
      ev <= 3'h0;
    end
    bus(IDX_AUX_CTRL, 1'b1, 8'h04);
    rx_dl_irq <= 1'b1;
    repeat (3) @(posedge clk);
    check("irq link", 32'h0, 32'(host_irq_n));
    check("link enable", 32'h1, 32'(rx_link_channel_en));
    rx_dl_irq <= 1'b0;
    bus(IDX_DL_CTRL, 1'b1, 8'h01);
    repeat (2) @(posedge clk);
    check("crc append", 32'h1, 32'(tx_crc_append_en));
    finish_test();
  end
endmodule // tb_t3e3_overhead_port_control

bind t3e3_overhead_port_control t3e3_overhead_port_control_assertions chk (
  .clk(clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .tx_msg_done(tx_msg_done), .tx_underrun(tx_underrun), .tx_near_empty(tx_near_empty),
  .rx_dl_irq(rx_dl_irq), .host_irq_n(host_irq_n), .rx_line_clk_in(rx_line_clk_in),
  .tx_line_clk_in(tx_line_clk_in), .tx_line_data_out(tx_line_data_out),
  .tx_bit_strobe(tx_bit_strobe), .rx_gapped_clk_out(rx_gapped_clk_out),
  .rx_field_marker_clk_out(rx_field_marker_clk_out));
